// ### rtl/sipo_store_pkg.sv
// Constants and carrier types for the shift-and-store bus register
// Functional notes
// R1 - The block has eight shift stages, each with its own storage latch bit driving one parallel output.
// R2 - The chain moves only on a rising shift clock edge, never on a falling one.
// R3 - On a rising edge the first stage takes the serial input and each later stage takes its predecessor.
// R4 - While the strobe is high each latch bit follows its shift stage.
// R5 - While the strobe is low the latch holds and the parallel outputs do not change.
// R6 - While output enable is high all parallel outputs drive the latch contents.
// R7 - While output enable is low all parallel outputs float.
// R8 - On a rising edge stage seven moves into stage eight and onto the fast cascade output.
// R9 - The slow cascade output shows stage eight, updated on the falling edge after the loading rise.
// R10 - The chaining party picks the fast cascade for fast clock edges and the slow one for slow edges.
// R11 - With no reset pin the shift, latch and cascade contents are undefined until data is loaded.
// R12 - The controller holds the strobe low while shifting eight bits and then pulses it once.
package sipo_store_pkg;
   localparam int STAGES = 8;
   localparam int LAST   = STAGES - 1;
   // Idle level loaded into every pin synchroniser by reset
   localparam logic [1:0] SYNC_IDLE = 2'h0;

   typedef struct packed {
      logic [STAGES-1:0] chain;
      logic [STAGES-1:0] store;
      logic              slow;
      logic [1:0]        clk_sync;
      logic [1:0]        data_sync;
      logic [1:0]        strobe_sync;
      logic [1:0]        oe_sync;
      logic              clk_prev;
   } state_s;

   typedef struct packed {
      logic [STAGES-1:0] data;
      logic [STAGES-1:0] oe;
   } par_pins_s;
endpackage

// ### rtl/sipo_store.sv
// Eight-stage shift register with storage latch and tri-state parallel outputs
`timescale 1ns/1ns
module sipo_store (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   clk_en,
   input  wire logic                   shift_clock_in,
   input  wire logic                   serial_in,
   input  wire logic                   latch_strobe,
   input  wire logic                   output_enable,
   output      sipo_store_pkg::par_pins_s parallel_out,
   output      logic                   fast_cascade_out,
   output      logic                   slow_cascade_out
);
   localparam int STAGES = sipo_store_pkg::STAGES;
   localparam int LAST   = sipo_store_pkg::LAST;

   sipo_store_pkg::state_s st;
   sipo_store_pkg::state_s next_st;
   logic                   rise;
   logic                   fall;
   logic [STAGES-1:0]      shifted;
   logic [STAGES-1:0]      next_chain;

   ////////////////////////////////////////////////////////////////////////////
   // The fast cascade tap needs a stage ahead of the last one
   if (STAGES < 2) begin : g_bad_stages
      $error("stage count must be at least 2");
   end

   if (LAST != STAGES - 1) begin : g_bad_last
      $error("last stage index must sit one below the stage count");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge decode shared by the rising and the falling detector
   function automatic logic edge_seen(
      input logic now_level,
      input logic prev_level,
      input logic want_high
   );
      edge_seen = (now_level == want_high) && (prev_level != want_high);
   endfunction

   // Pins are asynchronous, so each passes two flops first; only the
   // second flop of each pair feeds the logic below
   assign rise = edge_seen(st.clk_sync[1], st.clk_prev, 1'b1); // R2
   assign fall = edge_seen(st.clk_sync[1], st.clk_prev, 1'b0); // R9

   ////////////////////////////////////////////////////////////////////////////
   // Shift path: stage zero takes the serial pin, each later stage its neighbour
   assign shifted[0] = st.data_sync[1]; // R3

   for (genvar i = 1; i < STAGES; i++) begin : g_stage
      assign shifted[i] = st.chain[i-1]; // R1 R3
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st    = st;
      next_chain = st.chain;
      if (sys_rst) begin
         // Reset clears only the synchronisers and clk_prev; data stays unknown like the part
         next_st.clk_sync    = sipo_store_pkg::SYNC_IDLE;
         next_st.data_sync   = sipo_store_pkg::SYNC_IDLE;
         next_st.strobe_sync = sipo_store_pkg::SYNC_IDLE;
         next_st.oe_sync     = sipo_store_pkg::SYNC_IDLE;
         next_st.clk_prev    = 1'h0;
      end else begin
         next_st.clk_sync    = {st.clk_sync[0], shift_clock_in};
         next_st.data_sync   = {st.data_sync[0], serial_in};
         next_st.strobe_sync = {st.strobe_sync[0], latch_strobe};
         next_st.oe_sync     = {st.oe_sync[0], output_enable};
         next_st.clk_prev    = st.clk_sync[1];

         if (rise) begin
            next_chain = shifted; // R2 R3 R8
         end
         next_st.chain = next_chain; // R11

         // Transparent latch: follows the post-shift chain while strobe is high
         if (st.strobe_sync[1]) begin
            next_st.store = next_chain; // R4
         end

         // Slow tap trails the fast one by half a shift clock
         if (fall) begin
            next_st.slow = st.chain[LAST]; // R9
         end
      end
   end

   // One register for all state; a low clock enable freezes it whole
   always_ff @(posedge clk) begin
      if (clk_en) begin
         st <= next_st; // R5
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Float is signalled per pin; the pad ring turns a low enable into high-Z
   assign parallel_out.data = st.store; // R6
   assign parallel_out.oe   = {STAGES{st.oe_sync[1]}}; // R6 R7
   assign fast_cascade_out  = st.chain[LAST]; // R8
   assign slow_cascade_out  = st.slow; // R9

   ////////////////////////////////////////////////////////////////////////////
   // Case equality: stages hold unknowns until loaded, as the part does

   a_chain_shift: assert property (@(posedge clk) disable iff (sys_rst) // R3
      (clk_en && rise)
      |=> st.chain === {$past(st.chain[LAST-1:0]), $past(st.data_sync[1])})
      else $error("chain did not shift on rise");

   a_first_stage: assert property (@(posedge clk) disable iff (sys_rst) // R3
      (clk_en && rise)
      |=> st.chain[0] === $past(st.data_sync[1]))
      else $error("first stage missed the serial input");

   for (genvar k = 1; k < STAGES; k++) begin : g_stage_chk
      a_stage_step: assert property (@(posedge clk) disable iff (sys_rst) // R3
         (clk_en && rise)
         |=> st.chain[k] === $past(st.chain[k-1]))
         else $error("stage did not take its predecessor");
   end

   a_no_move_fall: assert property (@(posedge clk) disable iff (sys_rst) // R2
      !(clk_en && rise)
      |=> st.chain === $past(st.chain))
      else $error("chain moved without rising edge");

   a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst) // R5
      !(clk_en && st.strobe_sync[1])
      |=> parallel_out.data === $past(parallel_out.data))
      else $error("latch changed with strobe low");

   a_latch_follow: assert property (@(posedge clk) disable iff (sys_rst) // R4
      (clk_en && st.strobe_sync[1])
      |=> parallel_out.data === st.chain)
      else $error("latch not following chain");

   a_oe_drive: assert property (@(posedge clk) disable iff (sys_rst) // R6
      (clk_en && st.oe_sync[0])
      |=> parallel_out.oe == {STAGES{1'b1}})
      else $error("outputs not driven");

   a_oe_float: assert property (@(posedge clk) disable iff (sys_rst) // R7
      (clk_en && !st.oe_sync[0])
      |=> parallel_out.oe == {STAGES{1'b0}})
      else $error("outputs not floating");

   a_fast_casc: assert property (@(posedge clk) disable iff (sys_rst) // R8
      (clk_en && rise)
      |=> fast_cascade_out === $past(st.chain[LAST-1]))
      else $error("fast cascade wrong");

   a_slow_casc: assert property (@(posedge clk) disable iff (sys_rst) // R9
      (clk_en && fall)
      |=> slow_cascade_out === $past(st.chain[LAST]))
      else $error("slow cascade wrong");

   a_slow_hold: assert property (@(posedge clk) disable iff (sys_rst) // R9
      !(clk_en && fall)
      |=> slow_cascade_out === $past(slow_cascade_out))
      else $error("slow cascade moved off falling edge");

   // Reset must leave the data path alone, since the part has no reset pin
   a_rst_keeps: assert property (@(posedge clk) // R11
      (sys_rst && clk_en)
      |=> st.chain === $past(st.chain))
      else $error("reset disturbed the shift chain");

   a_rst_sync: assert property (@(posedge clk)
      (sys_rst && clk_en)
      |=> (st.clk_sync == 2'h0) && (st.clk_prev == 1'b0))
      else $error("reset left a shift clock edge pending");

   a_freeze_all: assert property (@(posedge clk)
      !clk_en
      |=> st === $past(st))
      else $error("state moved while clock enable was low");

endmodule

// ### sim/shift_ctrl_model.sv
// Controller model: shifts a byte first bit MSB, then pulses the strobe if latch is set
`timescale 1ns/1ns
module shift_ctrl_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       latch,
   input  wire logic [7:0] value,
   output logic            sck,
   output logic            sdata,
   output logic            strobe,
   output logic            busy
);
   int step = 72;
   // Eight clk per bit so each phase outlasts the pin synchronisers; sck idles low
   always_ff @(posedge clk) begin
      step   <= (go && !busy) ? 0 : (busy ? step + 1 : step);
      sck    <= (step < 64) && step[2];
      sdata  <= (step < 64) ? value[7 - step / 8] : ~value[0];
      strobe <= latch && (step >= 64) && (step < 72);
   end
   assign busy = step < 72;
endmodule

// ### sim/test_shift_and_store_bus_register.sv
// Self-checking bench for the shift-and-store bus register
`timescale 1ns/1ns
module test_shift_and_store_bus_register;
   logic                      clk = 1'b0, sys_rst = 1'b1, oe_pin = 1'b0, go = 1'b0;
   logic                      latch = 1'b0, sck, sdata, strobe, busy, fast, slow;
   logic                      clk_en = 1'b1;
   logic [7:0]                value = 8'h00;
   sipo_store_pkg::par_pins_s parallel_out;
   int                        errors = 0, checked = 0, cycles = 0;
   initial forever #5 clk = ~clk;
   sipo_store u_sipo_store (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .shift_clock_in(sck), .serial_in(sdata), .latch_strobe(strobe),
      .output_enable(oe_pin), .parallel_out(parallel_out),
      .fast_cascade_out(fast), .slow_cascade_out(slow));
   shift_ctrl_model u_shift_ctrl_model (.clk(clk), .go(go), .latch(latch),
      .value(value), .sck(sck), .sdata(sdata), .strobe(strobe), .busy(busy));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic send(input logic [7:0] v, input logic l, input logic oe);
      @(posedge clk);
      value  <= v;
      latch  <= l;
      oe_pin <= oe;
      go     <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
      // Let the two-flop pin synchronisers settle the last edges
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic test_load;
      send(8'hA5, 1'b1, 1'b1);
      check("data", parallel_out.data, 8'hA5);
      check("oe", parallel_out.oe, 8'hFF);
      check("fast", {7'h00, fast}, 8'h01);
      check("slow", {7'h00, slow}, 8'h01);
      $display("test_load done");
   endtask
   task automatic test_hold;
      send(8'h3C, 1'b0, 1'b1);
      check("held data", parallel_out.data, 8'hA5);
      check("fast", {7'h00, fast}, 8'h00);
      check("slow", {7'h00, slow}, 8'h00);
      $display("test_hold done");
   endtask
   task automatic test_float;
      send(8'h5A, 1'b1, 1'b0);
      check("float oe", parallel_out.oe, 8'h00);
      @(posedge clk);
      oe_pin <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check("data", parallel_out.data, 8'h5A);
      check("oe", parallel_out.oe, 8'hFF);
      $display("test_float done");
   endtask
   task automatic test_freeze;
      @(posedge clk);
      clk_en <= 1'b0;
      send(8'hC3, 1'b1, 1'b1);
      check("frozen data", parallel_out.data, 8'h5A);
      check("frozen fast", {7'h00, fast}, 8'h00);
      @(posedge clk);
      clk_en <= 1'b1;
      send(8'hC3, 1'b1, 1'b1);
      check("data", parallel_out.data, 8'hC3);
      check("fast", {7'h00, fast}, 8'h01);
      check("slow", {7'h00, slow}, 8'h01);
      $display("test_freeze done");
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      test_load();
      test_hold();
      test_float();
      test_freeze();
      stop_test();
   end
endmodule
